// ---- core/scsi_dma_pkg.sv ----
// Behaviour
// (RL1) Controller registers use a byte-wide port; controller makes its own register parity.
// (RL2) Channel data uses a separate byte-wide port; we add parity on channel writes.
// (RL3) A 32-byte main FIFO plus an 8-byte channel FIFO sit between bus and channel.
// (RL4) Read: wait for full FIFO, then request bus and move 32 bytes in 8 cycles.
// (RL5) Write: request bus first, then fetch 32 bytes in 8 bus cycles.
// (RL6) Write: after the FIFO is full, drain it byte by byte into the channel.
// (RL7) The path keeps up with 4 Mbyte/s byte traffic to and from the channel.
// (RL8) Each bus cycle carries one 32-bit word of four bytes, first byte in the top lane.
package scsi_dma_pkg;
	localparam int MAIN_DEPTH = 32;
	localparam int CHAN_DEPTH = 8;
	localparam int BYTES_PER_WORD = 4;
	localparam int WORDS_PER_BURST = MAIN_DEPTH / BYTES_PER_WORD;
	localparam logic [2:0] LAST_WORD = 3'(WORDS_PER_BURST - 1);
	localparam logic [1:0] LAST_BYTE = 2'(BYTES_PER_WORD - 1);
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam int CLK_NS = 20;
	localparam int BYTE_NS = 250;
	localparam int BYTE_CYCLES = BYTE_NS / CLK_NS;
	localparam logic [7:0] BLOCKS_NONE = 8'h00;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_RD_FILL = 4'b0001,
		S_RD_REQ = 4'b0010,
		S_RD_PACK = 4'b0011,
		S_RD_BUS = 4'b0100,
		S_WR_REQ = 4'b0101,
		S_WR_BUS = 4'b0110,
		S_WR_UNPACK = 4'b0111,
		S_WR_DRAIN = 4'b1000,
		S_DONE = 4'b1001
	} dma_state_t;
endpackage

// ---- core/byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire logic [7:0] i_wdata,
	input wire logic i_pop,
	output logic o_valid,
	output logic o_ready,
	output logic [7:0] o_rdata
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [7:0] head;
	} fifo_st_t;

	fifo_st_t q, d;
	logic do_push, do_pop;

	assign o_valid = q.cnt != '0;
	assign o_ready = q.cnt != FULL_CNT;
	assign o_rdata = q.head;

	always_comb begin
		d = q;
		do_push = i_push && o_ready;
		do_pop = i_pop && o_valid;
		if (do_push) begin
			d.mem[q.wp] = i_wdata;
			d.wp = q.wp + AW'(1);
		end
		if (do_pop) begin
			d.rp = q.rp + AW'(1);
		end
		if (do_push && !do_pop) begin
			d.cnt = q.cnt + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			d.cnt = q.cnt - (AW+1)'(1);
		end
		// Head register loads next-state memory at the next read pointer, so a write into that slot shows at once
		d.head = d.mem[d.rp];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	fifo_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_push && o_ready && !i_pop) |=> q.cnt == $past(q.cnt) + (AW+1)'(1))
		else $error("fifo count did not follow a push");
endmodule // byte_fifo
`default_nettype wire

// ---- core/scsi_dma_path.sv ----
`timescale 1ns/1ps
`default_nettype none
module scsi_dma_path
	import scsi_dma_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Transfer control
	input wire logic i_start,
	input wire logic i_to_scsi,
	input wire logic [31:0] i_addr,
	input wire logic [7:0] i_blocks,
	output logic o_busy,
	output logic o_done,
	// Local bus master
	output logic o_bus_req,
	input wire logic i_bus_grant,
	output logic o_bus_strobe,
	output logic o_bus_wr,
	output logic [31:0] o_bus_addr,
	output logic [31:0] o_bus_wdata,
	input wire logic i_bus_ack,
	input wire logic [31:0] i_bus_rdata,
	// Channel DMA byte port
	input wire logic i_sc_rd_valid,
	input wire logic [7:0] i_sc_rd_data,
	output logic o_sc_rd_ready,
	output logic o_sc_wr_valid,
	output logic [7:0] o_sc_wr_data,
	output logic o_sc_wr_par,
	output logic o_sc_wr_par_oe_n,
	input wire logic i_sc_wr_ready,
	// Controller register byte port
	input wire logic i_cpu_cs,
	input wire logic i_cpu_we,
	input wire logic [8:0] i_cpu_addr,
	input wire logic [7:0] i_cpu_wdata,
	output logic [7:0] o_cpu_rdata,
	output logic o_reg_cs,
	output logic o_reg_we,
	output logic [8:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_reg_par_oe_n,
	input wire logic [7:0] i_reg_rdata
);
	typedef struct packed {
		dma_state_t state;
		logic to_scsi;
		logic [31:0] addr;
		logic [7:0] blocks;
		logic [31:0] word;
		logic [1:0] bcnt;
		logic [2:0] wcnt;
		logic reg_cs;
		logic reg_we;
		logic [8:0] reg_addr;
		logic [7:0] reg_wdata;
		logic [7:0] cpu_rdata;
		logic flush;
	} path_st_t;

	path_st_t q, d;

	logic main_push, main_pop, main_valid, main_ready;
	logic [7:0] main_wdata, main_head;
	logic chan_push, chan_pop, chan_valid, chan_ready;
	logic [7:0] chan_wdata, chan_head;

	// --------------------------------------------------------------
	// Buffers
	// --------------------------------------------------------------
	byte_fifo #(.DEPTH(MAIN_DEPTH)) u_main_fifo ( // [RL3]
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_push(main_push),
		.i_wdata(main_wdata),
		.i_pop(main_pop),
		.o_valid(main_valid),
		.o_ready(main_ready),
		.o_rdata(main_head)
	);

	byte_fifo #(.DEPTH(CHAN_DEPTH)) u_chan_fifo ( // [RL3]
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_push(chan_push),
		.i_wdata(chan_wdata),
		.i_pop(chan_pop),
		.o_valid(chan_valid),
		.o_ready(chan_ready),
		.o_rdata(chan_head)
	);

	// --------------------------------------------------------------
	// Byte movers
	// --------------------------------------------------------------
	always_comb begin
		// On reads the channel side takes a byte every cycle it has room [RL7]
		o_sc_rd_ready = !q.to_scsi && chan_ready;
		// Bytes left over from a read are dropped, never sent back to the channel [RL6]
		o_sc_wr_valid = q.to_scsi && chan_valid && !q.flush;
		o_sc_wr_data = chan_head;
		o_sc_wr_par = ~^chan_head; // [RL2]
		o_sc_wr_par_oe_n = !o_sc_wr_valid; // [RL2]
		if (q.to_scsi) begin
			chan_push = (q.state == S_WR_DRAIN) && main_valid; // [RL6]
			chan_wdata = main_head;
			chan_pop = q.flush || i_sc_wr_ready;
			main_push = q.state == S_WR_UNPACK; // [RL8]
			main_wdata = q.word[31:24];
			main_pop = (q.state == S_WR_DRAIN) && chan_ready; // [RL6]
		end else begin
			chan_push = i_sc_rd_valid;
			chan_wdata = i_sc_rd_data;
			chan_pop = (q.state == S_RD_FILL) && main_ready;
			main_push = (q.state == S_RD_FILL) && chan_valid;
			main_wdata = chan_head;
			main_pop = q.state == S_RD_PACK; // [RL8]
		end
	end

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_comb begin
		d = q;
		// Register port forwarding; the controller drives its own parity [RL1]
		d.reg_cs = i_cpu_cs;
		d.reg_we = i_cpu_we;
		d.reg_addr = i_cpu_addr;
		d.reg_wdata = i_cpu_wdata;
		d.cpu_rdata = i_reg_rdata;
		if (!chan_valid) begin
			d.flush = 1'b0;
		end
		unique case (q.state)
			S_IDLE: begin
				if (i_start) begin
					d.to_scsi = i_to_scsi;
					d.addr = i_addr;
					d.blocks = i_blocks;
					d.flush = i_to_scsi; // [RL6]
					if (i_blocks == BLOCKS_NONE) begin
						d.state = S_DONE;
					end else if (i_to_scsi) begin
						d.state = S_WR_REQ; // [RL5]
					end else begin
						d.state = S_RD_FILL;
					end
				end
			end
			S_RD_FILL: begin
				if (!main_ready) begin
					d.state = S_RD_REQ; // [RL4]
				end
			end
			S_RD_REQ: begin
				d.wcnt = '0;
				d.bcnt = '0;
				if (i_bus_grant) begin
					d.state = S_RD_PACK;
				end
			end
			S_RD_PACK: begin
				d.word = {q.word[23:0], main_head}; // [RL8]
				d.bcnt = q.bcnt + 2'h1;
				if (q.bcnt == LAST_BYTE) begin
					d.state = S_RD_BUS;
				end
			end
			S_RD_BUS: begin
				if (i_bus_ack) begin
					d.addr = q.addr + WORD_STEP;
					d.wcnt = q.wcnt + 3'h1;
					if (q.wcnt == LAST_WORD) begin // [RL4]
						d.blocks = q.blocks - 8'h01;
						d.state = (q.blocks == 8'h01) ? S_DONE : S_RD_FILL;
					end else begin
						d.state = S_RD_PACK;
					end
				end
			end
			S_WR_REQ: begin
				d.wcnt = '0;
				if (i_bus_grant) begin
					d.state = S_WR_BUS;
				end
			end
			S_WR_BUS: begin
				if (i_bus_ack) begin
					d.word = i_bus_rdata;
					d.addr = q.addr + WORD_STEP;
					d.bcnt = '0;
					d.state = S_WR_UNPACK;
				end
			end
			S_WR_UNPACK: begin
				d.word = {q.word[23:0], 8'h00}; // [RL8]
				d.bcnt = q.bcnt + 2'h1;
				if (q.bcnt == LAST_BYTE) begin
					d.wcnt = q.wcnt + 3'h1;
					if (q.wcnt == LAST_WORD) begin // [RL5]
						d.blocks = q.blocks - 8'h01;
						d.state = S_WR_DRAIN;
					end else begin
						d.state = S_WR_BUS;
					end
				end
			end
			S_WR_DRAIN: begin
				if (!main_valid && q.blocks != BLOCKS_NONE) begin
					d.state = S_WR_REQ;
				end else if (!main_valid && !chan_valid) begin
					d.state = S_DONE;
				end
			end
			S_DONE: begin
				d.state = S_IDLE;
			end
			default: begin
				d.state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign o_busy = q.state != S_IDLE;
	assign o_done = q.state == S_DONE;
	assign o_bus_req = q.state inside {S_RD_REQ, S_RD_PACK, S_RD_BUS, S_WR_REQ, S_WR_BUS, S_WR_UNPACK};
	assign o_bus_strobe = (q.state == S_RD_BUS) || (q.state == S_WR_BUS);
	assign o_bus_wr = q.state == S_RD_BUS;
	assign o_bus_addr = q.addr;
	assign o_bus_wdata = q.word;
	assign o_cpu_rdata = q.cpu_rdata;
	assign o_reg_cs = q.reg_cs;
	assign o_reg_we = q.reg_we;
	assign o_reg_addr = q.reg_addr;
	assign o_reg_wdata = q.reg_wdata;
	assign o_reg_par_oe_n = 1'b1; // [RL1]

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	read_req_full_a: assert property ($rose(o_bus_req) && !q.to_scsi |-> !main_ready) // [RL4]
		else $error("bus requested before the read FIFO was full");
	read_burst_end_a: assert property ( // [RL4]
		q.state == S_RD_BUS && i_bus_ack && q.wcnt == LAST_WORD |=> !o_bus_req)
		else $error("read burst did not end after eight words");
	write_req_empty_a: assert property ($rose(o_bus_req) && q.to_scsi |-> !main_valid) // [RL5]
		else $error("write fetch began with bytes still buffered");
	write_unpack_a: assert property ( // [RL8]
		q.state == S_WR_BUS && i_bus_ack |=> (q.state == S_WR_UNPACK)[*4] ##1 q.state != S_WR_UNPACK)
		else $error("fetched word was not split into four bytes");
	read_pack_a: assert property ($rose(q.state == S_RD_BUS) |-> $past(q.state == S_RD_PACK, 4)) // [RL8]
		else $error("bus write not preceded by four packed bytes");
	write_drain_gate_a: assert property (q.to_scsi && main_pop |-> q.state == S_WR_DRAIN) // [RL6]
		else $error("write FIFO drained before it was filled");
	channel_parity_a: assert property ( // [RL2]
		o_sc_wr_valid |-> !o_sc_wr_par_oe_n && (^{o_sc_wr_par, o_sc_wr_data}))
		else $error("channel write parity wrong or not driven");
	reg_forward_a: assert property ( // [RL1]
		i_cpu_cs |=> o_reg_cs && o_reg_wdata == $past(i_cpu_wdata) && o_reg_par_oe_n)
		else $error("register access not forwarded as expected");
	read_accept_a: assert property (!q.to_scsi && chan_ready |-> o_sc_rd_ready) // [RL7]
		else $error("channel byte refused with room in the buffer");

	read_block_c: cover property (q.state == S_RD_BUS && i_bus_ack && q.wcnt == LAST_WORD);
	write_block_c: cover property (q.state == S_WR_UNPACK ##1 q.state == S_WR_DRAIN);
	chan_stall_c: cover property (!q.to_scsi && o_busy && !chan_ready);
	done_c: cover property (o_done);
endmodule // scsi_dma_path
`default_nettype wire

// ---- tb/far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module far_side (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic i_src_en,
	input wire logic i_req,
	input wire logic i_strobe,
	input wire logic i_wr,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	output var logic o_grant,
	output var logic o_ack,
	output logic [31:0] o_rdata,
	input wire logic i_rd_ready,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	input wire logic i_wr_valid,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_par,
	output logic o_wr_ready
);
	logic [31:0] mem [0:15];
	logic [8:0] got [0:63];
	int n_got = 0;
	int n_sent = 0;
	int n_ack = 0;
	int sent_at_req = -1;
	int first_ack = -1;
	logic tick = 1'b0;
	logic [7:0] last = 8'h00;
	logic stall;
	initial o_grant = 1'b0;
	initial o_ack = 1'b0;
	// ----------------------------------------
	// Channel bytes and memory bus
	// ----------------------------------------
	assign stall = i_slow && tick;
	assign o_rd_valid = i_src_en && !stall;
	assign o_rd_data = o_rd_valid ? 8'(n_sent) : ~last;
	assign o_wr_ready = !stall;
	assign o_rdata = o_ack ? mem[i_addr[5:2]] : ~mem[i_addr[5:2]];
	always @(posedge i_clk) begin
		tick <= ~tick;
		o_grant <= i_req;
		o_ack <= i_strobe && !o_ack && !stall;
		if (i_req && sent_at_req < 0) begin
			sent_at_req <= n_sent;
		end
		if (i_strobe && o_ack) begin
			n_ack <= n_ack + 1;
			if (i_wr) begin
				mem[i_addr[5:2]] <= i_wdata;
			end
		end
		if (o_rd_valid && i_rd_ready) begin
			last <= o_rd_data;
			n_sent <= n_sent + 1;
		end
		if (i_wr_valid && o_wr_ready) begin
			got[n_got[5:0]] <= {i_wr_par, i_wr_data};
			n_got <= n_got + 1;
			if (n_got == 0) begin
				first_ack <= n_ack;
			end
		end
	end
endmodule // far_side
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic start = 1'b0, to_scsi = 1'b0, slow = 1'b0, src_en = 1'b0, cs = 1'b0, we = 1'b0;
	logic [7:0] blocks = 8'h00, cpu_wdata = 8'h00, reg_rdata = 8'h00;
	logic [8:0] cpu_addr = 9'h000;
	logic [31:0] addr = 32'h0000_0000;
	logic busy, done, req, grant, strobe, bwr, ack, rdv, rdr, wrv, wpar, wpoe, wrr, reg_cs, reg_we, reg_poe;
	logic [31:0] baddr, bwdata, brdata;
	logic [7:0] rdd, wrd, cpu_rdata, reg_wdata;
	logic [8:0] reg_addr;
	int failures = 0;
	int check_count = 0;
	always #10 i_clk = ~i_clk;
	scsi_dma_path dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start), .i_to_scsi(to_scsi),
		.i_addr(addr), .i_blocks(blocks), .o_busy(busy), .o_done(done), .o_bus_req(req),
		.i_bus_grant(grant), .o_bus_strobe(strobe), .o_bus_wr(bwr), .o_bus_addr(baddr),
		.o_bus_wdata(bwdata), .i_bus_ack(ack), .i_bus_rdata(brdata), .i_sc_rd_valid(rdv),
		.i_sc_rd_data(rdd), .o_sc_rd_ready(rdr), .o_sc_wr_valid(wrv), .o_sc_wr_data(wrd),
		.o_sc_wr_par(wpar), .o_sc_wr_par_oe_n(wpoe), .i_sc_wr_ready(wrr), .i_cpu_cs(cs), .i_cpu_we(we),
		.i_cpu_addr(cpu_addr), .i_cpu_wdata(cpu_wdata), .o_cpu_rdata(cpu_rdata), .o_reg_cs(reg_cs),
		.o_reg_we(reg_we), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_par_oe_n(reg_poe),
		.i_reg_rdata(reg_rdata));
	far_side far (.i_clk(i_clk), .i_slow(slow), .i_src_en(src_en), .i_req(req), .i_strobe(strobe),
		.i_wr(bwr), .i_addr(baddr), .i_wdata(bwdata), .o_grant(grant), .o_ack(ack), .o_rdata(brdata),
		.i_rd_ready(rdr), .o_rd_valid(rdv), .o_rd_data(rdd), .i_wr_valid(wrv), .i_wr_data(wrd),
		.i_wr_par(wpar), .o_wr_ready(wrr));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic run(input logic dir, input logic [7:0] nb, output int n);
		@(posedge i_clk);
		start <= 1'b1;
		to_scsi <= dir;
		blocks <= nb;
		n = 0;
		do begin
			@(posedge i_clk);
			start <= 1'b0;
			#1;
			n++;
		end while (done !== 1'b1 && n < 3000);
		check(64'(done), 64'h1);
		@(posedge i_clk);
		#1;
		check(64'(busy), 64'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reg_test();
		check(reg_poe, 1'b1);
		check(wpoe, 1'b1);
		@(posedge i_clk);
		cs <= 1'b1;
		we <= 1'b1;
		cpu_addr <= 9'h1a5;
		cpu_wdata <= 8'h5c;
		reg_rdata <= 8'h3e;
		@(posedge i_clk);
		cs <= 1'b0;
		#1;
		check({reg_cs, reg_we, reg_addr, reg_wdata, cpu_rdata}, {2'h3, 9'h1a5, 8'h5c, 8'h3e});
		check(reg_poe, 1'b1);
	endtask
	task automatic zero_test();
		int n;
		run(1'b0, 8'h00, n);
		check(64'(n <= 2), 64'h1);
	endtask
	task automatic read_test();
		int n;
		src_en <= 1'b1;
		run(1'b0, 8'h02, n);
		check(64'(far.n_ack), 64'h10);
		check(baddr, 64'h40);
		check(64'(far.sent_at_req >= 32 && far.sent_at_req <= 42), 64'h1);
		for (int k = 0; k < 16; k++) begin
			check(far.mem[k], {8'(4 * k), 8'(4 * k + 1), 8'(4 * k + 2), 8'(4 * k + 3)});
		end
		src_en <= 1'b0;
	endtask
	task automatic write_test();
		int n;
		logic [7:0] b;
		for (int k = 0; k < 8; k++) begin
			far.mem[k + 8] = {8'(128 + 4 * k), 8'(129 + 4 * k), 8'(130 + 4 * k), 8'(131 + 4 * k)};
		end
		slow <= 1'b1;
		addr <= 32'h0000_0020;
		run(1'b1, 8'h01, n);
		check(baddr, 64'h40);
		check(64'(far.n_got), 64'h20);
		check(64'(far.first_ack), 64'h18);
		for (int j = 0; j < 32; j++) begin
			b = 8'(128 + j);
			check(far.got[j], {~(^b), b});
		end
		slow <= 1'b0;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		reg_test();
		zero_test();
		read_test();
		write_test();
		stop_test();
	end
	initial begin
		#400000;
		failures++;
		stop_test();
	end
endmodule // testbench
`default_nettype wire
